// ---- hw/ccp_ctrl_pkg.sv ----
`default_nettype none

package ccp_ctrl_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] OFF_CONTROL_TWO   = 8'h00;
    localparam logic [7:0] OFF_CONTROL_THREE = 8'h04;
    localparam logic [7:0] OFF_MODE_CONTROL  = 8'h08;
    localparam logic [7:0] OFF_STATUS        = 8'h0C;

    // Reset values; the pin A enable comes up set.
    localparam logic [31:0] RST_CONTROL_TWO   = 32'h0100_0000;
    localparam logic [31:0] RST_CONTROL_THREE = 32'h0000_0000;
    localparam logic [31:0] RST_MODE_CONTROL  = 32'h0000_0000;

    // Writable bits, multi- and single-output variants.
    localparam logic [31:0] MASK_TWO_MULTI    = 32'hBFDF_D0FF;
    localparam logic [31:0] MASK_TWO_SINGLE   = 32'h81DF_D0FF;
    localparam logic [31:0] MASK_THREE_MULTI  = 32'hF73F_003F;
    localparam logic [31:0] MASK_THREE_SINGLE = 32'hF02C_0000;
    localparam logic [31:0] MASK_MODE_CONTROL = 32'h0000_0003;

    // Control two field positions.
    localparam int POS_OE_SYNC       = 31;
    localparam int POS_PIN_EN        = 24;
    localparam int POS_GATE_MODE     = 22;
    localparam int POS_AUX_SEL       = 19;
    localparam int POS_CAP_SRC       = 16;
    localparam int POS_AUTO_RESTART  = 15;
    localparam int POS_SD_GATE_MODE  = 14;
    localparam int POS_SW_FORCE      = 12;
    localparam int POS_SD_SRC_EN     = 0;

    // Control three field positions.
    localparam int POS_HOLD_TRIG     = 31;
    localparam int POS_ONE_SHOT_CNT  = 28;
    localparam int POS_OUT_MODE      = 24;
    localparam int POS_POL_ACE       = 21;
    localparam int POS_POL_BDF       = 20;
    localparam int POS_SD_STATE_ACE  = 18;
    localparam int POS_SD_STATE_BDF  = 16;

    // Mode control and status field positions.
    localparam int POS_TRIG_EN       = 0;
    localparam int POS_ONE_SHOT_EN   = 1;
    localparam int POS_ST_TRIGGERED  = 7;
    localparam int POS_ST_TRIG_CLEAR = 5;
    localparam int POS_ST_SHUTDOWN   = 4;
    localparam int POS_ST_CAP_DIS    = 2;

    // Capture gate modes.
    localparam logic [1:0] GATE_LEVEL   = 2'b00;
    localparam logic [1:0] GATE_RISE_EN = 2'b01;
    localparam logic [1:0] GATE_FALL_DI = 2'b10;

    // Auxiliary output selections.
    localparam logic [1:0] AUX_OFF      = 2'b00;
    localparam logic [1:0] AUX_ROLLOVER = 2'b01;
    localparam logic [1:0] AUX_MODE_SIG = 2'b10;

    // Output modes.
    localparam logic [2:0] OUTM_STEER    = 3'b000;
    localparam logic [2:0] OUTM_PUSHPULL = 3'b001;
    localparam logic [2:0] OUTM_HALF     = 3'b010;
    localparam logic [2:0] OUTM_BDC_REV  = 3'b100;
    localparam logic [2:0] OUTM_BDC_FWD  = 3'b101;
    localparam logic [2:0] OUTM_SCAN     = 3'b110;

    // Shutdown pin states; top bit clear floats the pins.
    localparam logic [1:0] PSS_ACTIVE   = 2'b11;
    localparam logic [1:0] PSS_INACTIVE = 2'b10;

endpackage : ccp_ctrl_pkg

`default_nettype wire

// ---- hw/capture_gate.sv ----
`timescale 1ns/1ps
`default_nettype none

module capture_gate
    import ccp_ctrl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] gate_mode,
    input  wire logic       gate_level,
    input  wire logic       flag_clear,
    input  wire logic [7:0] sources,
    input  wire logic [2:0] source_sel,
    output logic            capture_disable_flag,
    output logic            capture_event
);

    logic gate_prev_reg;
    logic src_prev_reg;
    logic flag_next;
    logic src_now;
    logic gate_rise;
    logic gate_fall;

    // Source select indexes pin, comparators one to three, then logic cells.
    assign src_now   = sources[source_sel];
    assign gate_rise = gate_level & ~gate_prev_reg;
    assign gate_fall = ~gate_level & gate_prev_reg;

    // Gate mode decides how the gating source moves the disable flag.
    always_comb begin
        flag_next = capture_disable_flag & ~flag_clear;
        unique case (gate_mode)
            GATE_LEVEL:   flag_next = ~gate_level;
            GATE_RISE_EN: flag_next = gate_rise ? 1'b0 : flag_next;
            GATE_FALL_DI: flag_next = gate_fall | flag_next;
            default:      flag_next = capture_disable_flag;
        endcase
    end

    // Edge history and flag state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            gate_prev_reg        <= 1'b0;
            src_prev_reg         <= 1'b0;
            capture_disable_flag <= 1'b0;
            capture_event        <= 1'b0;
        end else begin
            gate_prev_reg        <= gate_level;
            src_prev_reg         <= src_now;
            capture_disable_flag <= flag_next;
            capture_event        <= src_now & ~src_prev_reg & ~capture_disable_flag;
        end
    end

endmodule : capture_gate

`default_nettype wire

// ---- hw/one_shot_stretch.sv ----
`timescale 1ns/1ps
`default_nettype none

module one_shot_stretch #(
    parameter int CNT_W = 3
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             trigger,
    input  wire logic             count_tick,
    input  wire logic [CNT_W-1:0] extend_count,
    output logic                  active
);

    logic [CNT_W-1:0] left_reg;

    // A trigger opens the window; each timer tick uses one period, n plus one in all.
    always_ff @(posedge mclk) begin
        if (rst) begin
            active   <= 1'b0;
            left_reg <= '0;
        end else if (trigger) begin
            active   <= 1'b1;
            left_reg <= extend_count;
        end else if (active && count_tick) begin
            active   <= (left_reg != '0);
            left_reg <= left_reg - 1'b1;
        end
    end

endmodule : one_shot_stretch

`default_nettype wire

// ---- hw/ccp_output_gating_shutdown_ctrl.sv ----
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ccp_output_gating_shutdown_ctrl
    import ccp_ctrl_pkg::*;
#(
    parameter bit MULTI_OUTPUT = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        tb_rollover,
    input  wire logic        period_start,
    input  wire logic        timer_tick,
    input  wire logic        trigger_in,
    input  wire logic        timer_mode,
    input  wire logic        mode_signal,
    input  wire logic        compare_event,
    input  wire logic        pwm_primary,
    input  wire logic        pwm_complement,
    input  wire logic        push_pull_phase,
    input  wire logic        capture_input_pin,
    input  wire logic [2:0]  comparator,
    input  wire logic [3:0]  logic_cell,
    input  wire logic [1:0]  sibling_output,
    input  wire logic        fault_pin_a,
    input  wire logic        fault_pin_b,
    output logic [5:0]       pin_out,
    output logic [5:0]       pin_oe_n,
    output logic [5:0]       pin_owned,
    output logic             aux_out,
    output logic             capture_event,
    output logic             shutdown_active_status
);

    // Merge enabled byte lanes of a write, keeping read-only bits.
    function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  strobe,
                                                input logic [31:0] mask);
        logic [31:0] lane;
        lane = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}}, {8{strobe[0]}}} & mask;
        merge_write = (old_val & ~lane) | (new_val & lane);
    endfunction : merge_write

    // Pin level for a given logical drive and polarity.
    function automatic logic pin_level(input logic drive, input logic active_low);
        pin_level = drive ^ active_low;
    endfunction : pin_level

    localparam logic [31:0] MASK_TWO   = MULTI_OUTPUT ? MASK_TWO_MULTI : MASK_TWO_SINGLE;
    localparam logic [31:0] MASK_THREE = MULTI_OUTPUT ? MASK_THREE_MULTI : MASK_THREE_SINGLE;

    logic [31:0] ccp_control_two_reg;
    logic [31:0] ccp_control_three_reg;
    logic [31:0] mode_control_reg;
    logic [5:0]  oe_active_reg;
    logic [5:0]  oe_active_next;
    logic        shutdown_next;
    logic        triggered_reg;
    logic        triggered_next;

    // Field views of the control registers.
    wire         output_enable_sync        = ccp_control_two_reg[POS_OE_SYNC];
    wire  [5:0]  output_pin_enables        = ccp_control_two_reg[POS_PIN_EN +: 6];
    wire  [1:0]  capture_gate_mode         = ccp_control_two_reg[POS_GATE_MODE +: 2];
    wire  [1:0]  aux_event_select          = ccp_control_two_reg[POS_AUX_SEL +: 2];
    wire  [2:0]  capture_source_select     = ccp_control_two_reg[POS_CAP_SRC +: 3];
    wire         pwm_auto_restart          = ccp_control_two_reg[POS_AUTO_RESTART];
    wire         shutdown_gate_mode        = ccp_control_two_reg[POS_SD_GATE_MODE];
    wire         software_shutdown_force   = ccp_control_two_reg[POS_SW_FORCE];
    wire  [7:0]  shutdown_source_enables   = ccp_control_two_reg[POS_SD_SRC_EN +: 8];
    wire         hold_outputs_until_trigger = ccp_control_three_reg[POS_HOLD_TRIG];
    wire  [2:0]  one_shot_extend_count     = ccp_control_three_reg[POS_ONE_SHOT_CNT +: 3];
    wire  [2:0]  output_mode_select        = ccp_control_three_reg[POS_OUT_MODE +: 3];
    wire         polarity_pins_ace         = ccp_control_three_reg[POS_POL_ACE];
    wire         polarity_pins_bdf         = ccp_control_three_reg[POS_POL_BDF];
    wire  [1:0]  shutdown_state_pins_ace   = ccp_control_three_reg[POS_SD_STATE_ACE +: 2];
    wire  [1:0]  shutdown_state_pins_bdf   = ccp_control_three_reg[POS_SD_STATE_BDF +: 2];
    wire         triggered_mode_enable     = mode_control_reg[POS_TRIG_EN];
    wire         one_shot_enable           = mode_control_reg[POS_ONE_SHOT_EN];

    // APB decode; the slave always answers in the first access cycle.
    wire setup_phase = psel & ~penable;
    wire access_wr   = psel & penable & pwrite;
    wire hit_two     = (paddr == OFF_CONTROL_TWO);
    wire hit_three   = (paddr == OFF_CONTROL_THREE);
    wire hit_mode    = (paddr == OFF_MODE_CONTROL);
    wire hit_status  = (paddr == OFF_STATUS);
    wire mapped      = hit_two | hit_three | hit_mode | hit_status;
    wire wr_two      = access_wr & hit_two;
    wire wr_three    = access_wr & hit_three;
    wire wr_mode     = access_wr & hit_mode;
    wire wr_status   = access_wr & hit_status & pstrb[0];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Status clears are write-one on the low byte.
    wire shutdown_sw_clear = wr_status & pwdata[POS_ST_SHUTDOWN];
    wire cap_flag_clear    = wr_status & pwdata[POS_ST_CAP_DIS];
    wire trig_sw_clear     = wr_status & pwdata[POS_ST_TRIG_CLEAR];

    // Shutdown request is the OR of every armed source plus the software force.
    wire [7:0] sd_sources = {fault_pin_b, fault_pin_a, logic_cell[0], sibling_output,
                             comparator[2], comparator[1], comparator[0]};
    wire shutdown_req = |(sd_sources & shutdown_source_enables)
                        | software_shutdown_force;

    // Gate mode defers a new shutdown to the next time base reset or rollover.
    wire shutdown_start = shutdown_req & (~shutdown_gate_mode | tb_rollover);

    // Automatic restart at the first period start once the request has gone.
    wire shutdown_auto_end = pwm_auto_restart & ~shutdown_req & period_start;

    // A new shutdown wins over either kind of clear.
    always_comb begin
        shutdown_next = shutdown_active_status;
        if (shutdown_auto_end || shutdown_sw_clear) begin
            shutdown_next = 1'b0;
        end
        if (shutdown_start) begin
            shutdown_next = 1'b1;
        end
    end

    // Enable bits reach the pins at once, or at rollover when sync is set.
    always_comb begin
        oe_active_next = oe_active_reg;
        if (!output_enable_sync || tb_rollover) begin
            oe_active_next = output_pin_enables;
        end
    end

    // Trigger state: a latch, or the stretched one-shot window.
    logic one_shot_active;

    one_shot_stretch #(
        .CNT_W(3)
    ) u_one_shot (
        .mclk        (mclk),
        .rst         (rst),
        .trigger     (trigger_in & triggered_mode_enable & one_shot_enable),
        .count_tick  (timer_tick),
        .extend_count(one_shot_extend_count),
        .active      (one_shot_active)
    );

    always_comb begin
        triggered_next = triggered_reg;
        if (trig_sw_clear || !triggered_mode_enable) begin
            triggered_next = 1'b0;
        end
        if (trigger_in && triggered_mode_enable) begin
            triggered_next = 1'b1;
        end
    end

    wire triggered = one_shot_enable ? one_shot_active : triggered_reg;

    // Enabled pins stay undriven in triggered mode with the hold bit set until the trigger comes, except during a shutdown, where the shutdown pin states decide.
    wire hold_pins = triggered_mode_enable & hold_outputs_until_trigger
                     & ~triggered;

    // Capture path: gating source is the combined shutdown request.
    logic capture_disable_flag;

    capture_gate u_capture_gate (
        .mclk                (mclk),
        .rst                 (rst),
        .gate_mode           (capture_gate_mode),
        .gate_level          (~shutdown_req),
        .flag_clear          (cap_flag_clear),
        .sources             ({logic_cell, comparator, capture_input_pin}),
        .source_sel          (capture_source_select),
        .capture_disable_flag(capture_disable_flag),
        .capture_event       (capture_event)
    );

    // Auxiliary event output selection.
    logic aux_next;

    always_comb begin
        unique case (aux_event_select)
            AUX_OFF:      aux_next = 1'b0;
            AUX_ROLLOVER: aux_next = tb_rollover;
            AUX_MODE_SIG: aux_next = mode_signal;
            default:      aux_next = ~timer_mode & (capture_event | compare_event);
        endcase
    end

    // Logical drive per pin from the output mode; reserved codes keep pins inactive.
    logic [5:0] drive;

    always_comb begin
        drive = 6'b00_0000;
        unique case (output_mode_select)
            OUTM_STEER, OUTM_SCAN: begin
                drive = {6{pwm_primary}};
            end
            OUTM_PUSHPULL: begin
                drive[0] = pwm_primary & push_pull_phase;
                drive[1] = pwm_primary & ~push_pull_phase;
            end
            OUTM_HALF: begin
                drive[0] = pwm_primary;
                drive[1] = pwm_complement;
            end
            OUTM_BDC_REV: begin
                drive[2] = 1'b1;
                drive[1] = pwm_primary;
            end
            OUTM_BDC_FWD: begin
                drive[0] = 1'b1;
                drive[3] = pwm_primary;
            end
            default: begin
                drive = 6'b00_0000;
            end
        endcase
    end

    // Pin levels, enables and ownership; index 0 is pin A through 5 for pin F.
    logic [5:0] pin_out_next;
    logic [5:0] pin_oe_n_next;

    always_comb begin
        logic       pol;
        logic [1:0] pss;
        pol = 1'b0;
        pss = 2'b00;
        for (int i = 0; i < 6; i++) begin
            pol = (i % 2 == 0) ? polarity_pins_ace : polarity_pins_bdf;
            pss = (i % 2 == 0) ? shutdown_state_pins_ace : shutdown_state_pins_bdf;
            pin_out_next[i]  = pin_level(drive[i], pol);
            pin_oe_n_next[i] = ~oe_active_reg[i] | hold_pins;
            if (shutdown_active_status) begin
                pin_out_next[i]  = pin_level(pss == PSS_ACTIVE, pol);
                pin_oe_n_next[i] = ~oe_active_reg[i] | ~pss[1];
            end
        end
    end

    // Register file, state and data outputs.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ccp_control_two_reg    <= RST_CONTROL_TWO;
            ccp_control_three_reg  <= RST_CONTROL_THREE;
            mode_control_reg       <= RST_MODE_CONTROL;
            oe_active_reg          <= RST_CONTROL_TWO[POS_PIN_EN +: 6];
            shutdown_active_status <= 1'b0;
            triggered_reg          <= 1'b0;
            aux_out                <= 1'b0;
            pin_out                <= 6'b00_0000;
            pin_oe_n               <= 6'b11_1111;
            pin_owned              <= 6'b00_0000;
        end else begin
            if (wr_two) begin
                ccp_control_two_reg <= merge_write(ccp_control_two_reg, pwdata, pstrb,
                                                   MASK_TWO);
            end
            if (wr_three) begin
                ccp_control_three_reg <= merge_write(ccp_control_three_reg, pwdata, pstrb,
                                                     MASK_THREE);
            end
            if (wr_mode) begin
                mode_control_reg <= merge_write(mode_control_reg, pwdata, pstrb,
                                                MASK_MODE_CONTROL);
            end
            oe_active_reg          <= oe_active_next;
            shutdown_active_status <= shutdown_next;
            triggered_reg          <= triggered_next;
            aux_out                <= aux_next;
            pin_out                <= pin_out_next;
            pin_oe_n               <= pin_oe_n_next;
            pin_owned              <= oe_active_reg;
        end
    end

    // Read data loads at setup and stands through the access cycle.
    logic [31:0] rd_value;
    logic [31:0] status_value;

    always_comb begin
        status_value = 32'h0000_0000;
        status_value[POS_ST_TRIGGERED] = triggered;
        status_value[POS_ST_SHUTDOWN]  = shutdown_active_status;
        status_value[POS_ST_CAP_DIS]   = capture_disable_flag;
        rd_value = 32'h0000_0000;
        if (hit_two) begin
            rd_value = ccp_control_two_reg;
        end else if (hit_three) begin
            rd_value = ccp_control_three_reg;
        end else if (hit_mode) begin
            rd_value = mode_control_reg;
        end else if (hit_status) begin
            rd_value = status_value;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= rd_value;
        end
    end

endmodule : ccp_output_gating_shutdown_ctrl

`default_nettype wire

// ---- bench/ccp_output_gating_shutdown_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccp_ctrl_checker
    import ccp_ctrl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        tb_rollover,
    input wire logic        period_start,
    input wire logic [2:0]  comparator,
    input wire logic [1:0]  sibling_output,
    input wire logic        fault_pin_a,
    input wire logic        fault_pin_b,
    input wire logic [5:0]  pin_owned,
    input wire logic        aux_out,
    input wire logic        shutdown_active_status
);
    logic [31:0] ctl_reg;
    logic        wr_two;
    logic        wr_stat;
    logic        req;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Write decode and shutdown request; logic cell source left out.
    assign wr_two  = psel && penable && pwrite && paddr == OFF_CONTROL_TWO;
    assign wr_stat = psel && penable && pwrite && paddr == OFF_STATUS;
    assign req = |({fault_pin_b, fault_pin_a, 1'b0, sibling_output, comparator} & ctl_reg[7:0])
                 || ctl_reg[POS_SW_FORCE];
    // Shadow of control two, assuming full-word writes.
    always_ff @(posedge mclk) begin
        if (rst) ctl_reg <= RST_CONTROL_TWO;
        else if (wr_two) ctl_reg <= pwdata & MASK_TWO_MULTI;
    end
    sequence sd_now;
        !ctl_reg[POS_SD_GATE_MODE] && req;
    endsequence
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    AST_SD_IMMEDIATE: assert property (sd_now |=> shutdown_active_status)
        else $error("shutdown status did not follow request");
    AST_SD_DEFERRED: assert property (ctl_reg[POS_SD_GATE_MODE] && !tb_rollover
        && !shutdown_active_status |=> !shutdown_active_status)
        else $error("shutdown not deferred to rollover");
    AST_SD_HELD: assert property (!ctl_reg[POS_AUTO_RESTART] && !wr_stat
        && shutdown_active_status |=> shutdown_active_status)
        else $error("shutdown status dropped without software clear");
    AST_SD_RESTART: assert property (ctl_reg[POS_AUTO_RESTART] && period_start && !req
        && !$past(req) && !wr_stat && shutdown_active_status |=> !shutdown_active_status)
        else $error("auto restart did not clear status");
    AST_OE_NOW: assert property (wr_two && !pwdata[31] |=> ##2
        pin_owned == $past(pwdata[29:24], 3))
        else $error("pin enables not applied at once");
    AST_OE_SYNC: assert property (ctl_reg[POS_OE_SYNC] && !tb_rollover |-> ##2 $stable(pin_owned))
        else $error("pin enables changed between rollovers");
    AST_AUX_ROLL: assert property (ctl_reg[20:19] == AUX_ROLLOVER |=> aux_out == $past(tb_rollover))
        else $error("aux output does not follow rollover");
endmodule : ccp_ctrl_checker

bind ccp_output_gating_shutdown_ctrl ccp_ctrl_checker ccp_ctrl_checker_i (.*);
`default_nettype wire

// ---- bench/pin_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Comparators, logic cells, sibling outputs, fault and capture pins of the far side.
module pin_side_model (
    input wire logic        mclk,
    input wire logic        slow,
    input wire logic [11:0] level,
    output logic            capture_input_pin,
    output logic [2:0]      comparator,
    output logic [3:0]      logic_cell,
    output logic [1:0]      sibling_output,
    output logic            fault_pin_a,
    output logic            fault_pin_b
);
    logic [11:0] stage_reg = 12'h000;
    logic [11:0] out_reg   = 12'h000;
    // Sources settle one edge after a request, or two when slow.
    always @(posedge mclk) begin
        stage_reg <= level;
        out_reg   <= slow ? stage_reg : level;
    end
    assign {fault_pin_b, fault_pin_a, sibling_output, logic_cell, comparator,
            capture_input_pin} = out_reg;
endmodule : pin_side_model
`default_nettype wire

// ---- bench/ccp_output_gating_shutdown_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccp_output_gating_shutdown_ctrl_test;
    import ccp_ctrl_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [11:0] level = 12'h000;
    logic tb_rollover = 1'b0, period_start = 1'b0, pwm_primary = 1'b0, trigger_in = 1'b0, err;
    logic pready, pslverr, capture_input_pin, fault_pin_a, fault_pin_b, aux_out;
    logic capture_event, shutdown_active_status;
    logic [2:0] comparator;
    logic [3:0] logic_cell;
    logic [1:0] sibling_output;
    logic [5:0] pin_out, pin_oe_n, pin_owned;
    int failures = 0, tests_run = 0, cyc_cnt = 0, cap_cnt = 0, exp_cap = 0;
    int sd_bit[7] = '{0, 1, 2, 3, 4, 6, 7};
    int sd_src[7] = '{1, 2, 3, 8, 9, 10, 11};
    logic [31:0] model[4];
    logic [31:0] msk[4] = '{MASK_TWO_MULTI, MASK_THREE_MULTI, MASK_MODE_CONTROL, 32'h0};
    ccp_output_gating_shutdown_ctrl ccp_output_gating_shutdown_ctrl_i (
        .*, .timer_tick(1'b0), .timer_mode(1'b0), .mode_signal(pwm_primary),
        .compare_event(1'b0), .pwm_complement(1'b0), .push_pull_phase(1'b0));
    pin_side_model pin_side_model_i (.*);
    always #12.5 mclk = ~mclk;
    // Counts capture pulses and cuts a hung run short.
    always @(posedge mclk) begin
        cap_cnt += int'(capture_event === 1'b1);
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; writes to the three control registers update the model.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (w && a < 8'h0C) model[a[3:2]] = d & msk[a[3:2]];
        @(posedge mclk);
    endtask : apb
    task automatic pulse_wait(input int k, input int n);
        {trigger_in, period_start, tb_rollover} <= 3'(1 << k);
        @(posedge mclk);
        {trigger_in, period_start, tb_rollover} <= 3'b000;
        repeat (n) @(posedge mclk);
    endtask : pulse_wait
    initial begin
        void'($urandom(32'h1c1965ca));
        model = '{RST_CONTROL_TWO, RST_CONTROL_THREE, RST_MODE_CONTROL, 32'h0};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 0);
            chk(rdat, model[i]);
            apb(1'b1, 8'(4 * i), $urandom());
            apb(1'b0, 8'(4 * i), 0);
            chk(rdat, model[i]);
        end
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk(err, 1);
        apb(1'b1, OFF_CONTROL_THREE, 32'h8000_0000);
        apb(1'b1, OFF_MODE_CONTROL, 1);
        apb(1'b1, OFF_CONTROL_TWO, 32'h3F00_0000);
        apb(1'b1, OFF_STATUS, 32'h10);
        chk(pin_oe_n, 6'h3F);
        pulse_wait(2, 2);
        chk(pin_oe_n, 6'h00);
        apb(1'b1, OFF_MODE_CONTROL, 0);
        chk({pin_owned, pin_oe_n}, 12'hFC0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFF_CONTROL_THREE, 32'h0020_0000 >> i);
            @(posedge mclk);
            chk(pin_out, i ? 6'h2A : 6'h15);
        end
        apb(1'b1, OFF_CONTROL_TWO, 32'h8508_0000);
        repeat (3) @(posedge mclk);
        chk(pin_owned, 6'h3F);
        pulse_wait(0, 2);
        chk(pin_owned, 6'h05);
        apb(1'b1, OFF_CONTROL_TWO, 32'h0500_0000);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, OFF_CONTROL_THREE, i[0] ? 32'h0008_0000 : 32'h0);
            apb(1'b1, OFF_CONTROL_TWO, 32'h0100_0000 | (32'h1 << sd_bit[i]));
            slow  <= i[0];
            level <= 12'(1 << sd_src[i]);
            repeat (5) @(posedge mclk);
            chk(shutdown_active_status, 1);
            chk({pin_oe_n[0], pin_out[0]}, i[0] ? 2'b00 : 2'b10);
            level <= 12'h000;
            repeat (5) @(posedge mclk);
            chk(shutdown_active_status, 1);
            apb(1'b1, OFF_STATUS, 32'h10);
            chk(shutdown_active_status, 0);
        end
        apb(1'b1, OFF_CONTROL_TWO, 32'h0108_5000);
        repeat (3) @(posedge mclk);
        chk(shutdown_active_status, 0);
        pulse_wait(0, 1);
        chk(shutdown_active_status, 1);
        apb(1'b1, OFF_CONTROL_TWO, 32'h0100_8040);
        apb(1'b1, OFF_STATUS, 32'h10);
        level <= 12'h400;
        repeat (4) @(posedge mclk);
        level <= 12'h000;
        repeat (4) @(posedge mclk);
        chk(shutdown_active_status, 1);
        pulse_wait(1, 1);
        chk(shutdown_active_status, 0);
        for (int c = 0; c < 9; c++) begin
            apb(1'b1, OFF_CONTROL_TWO, c == 8 ? 32'h0100_1000 : 32'h0100_0000 | (c << 16));
            level <= 12'(1 << (c % 8));
            repeat (4) @(posedge mclk);
            level <= 12'h000;
            repeat (3) @(posedge mclk);
            exp_cap += int'(c < 8);
            chk(cap_cnt, exp_cap);
        end
        report_and_stop();
    end
endmodule : ccp_output_gating_shutdown_ctrl_test
`default_nettype wire
